// [rtl/sbst_cfg.svh]
`ifndef SBST_CFG_SVH
`define SBST_CFG_SVH
`define SBST_IR_W 3
`define SBST_ID_W 32
`define SBST_BSR_W 109
`define SBST_BUMP_W 108
`define SBST_IR_CAPTURE 3'h1
`define SBST_IR_EXTEST 3'h0
`define SBST_IR_IDCODE 3'h1
`define SBST_IR_SAMPLEZ 3'h2
`define SBST_IR_SAMPLE 3'h4
`define SBST_IR_BYPASS 3'h7
// revision, part and maker codes below are arbitrary values
`define SBST_ID_REV 3'h5
`define SBST_ID_PART 17'h0ABCD
`define SBST_ID_MAKER 11'h2AA
`define SBST_OEN_CELL_IDX 108
`endif

// [rtl/sbst_pkg.sv]
package sbst_pkg;
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PA_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PA_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } sbst_state_t;
    typedef struct packed {
        logic tms;
        logic tdi;
    } sbst_link_t;
endpackage : sbst_pkg

// [rtl/sbst_tap.sv]
// Overview of operation
// - instruction 3 bits, bypass 1, identification 32, boundary chain 109 cells
// - code 000 captures pin ring into boundary chain and shifts it
// - code 001 loads fixed identification code and shifts it, memory undisturbed
// - code 010 captures pins, shifts boundary chain, floats all memory outputs
// - code 100 captures pins and shifts boundary chain, memory undisturbed
// - code 111 selects single-bit bypass, memory undisturbed
// - id fields: revision 31:29, part 28:12, maker 11:1, all constants
// - id bit zero always reads one
// - mode select high for five test-clock edges resets the port
// - capture-instruction loads low two instruction bits with 01
// - reset and test-logic-reset make identification the current instruction
// - under code 000 latched cell 108 enables read drivers; presets high
`timescale 1ns/1ps
`include "sbst_cfg.svh"
module sbst_tap (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic tck_i,
    input wire sbst_pkg::sbst_link_t link_i,
    output logic tdo_o,
    output logic tdo_oe_n_o,
    input wire logic [`SBST_BUMP_W-1:0] pins_i,
    output logic [`SBST_BUMP_W-1:0] pins_o,
    output logic extest_o,
    output logic q_drive_en_o,
    output logic [`SBST_IR_W-1:0] ir_o
);
    localparam logic [`SBST_ID_W-1:0] ID_CODE =
        {`SBST_ID_REV, `SBST_ID_PART, `SBST_ID_MAKER, 1'b1};

    // reset and enable leave clk_sys_i from flops, so the crossing never sees a glitch
    logic rst_sys_r;
    logic ce_sys_r;
    logic [1:0] rst_sync_r;
    logic trst_n;
    sbst_pkg::sbst_state_t state_r;
    sbst_pkg::sbst_state_t state_nxt;
    logic [`SBST_IR_W-1:0] ir_sh_r;
    logic [`SBST_IR_W-1:0] ir_r;
    logic byp_r;
    logic [`SBST_ID_W-1:0] id_r;
    logic [`SBST_BSR_W-1:0] bsr_r;
    logic [`SBST_BSR_W-1:0] upd_r;
    logic [1:0] ce_sync_r;
    logic tce;
    logic tdo_nxt;
    logic sel_bsr;
    logic [`SBST_BUMP_W-1:0] pins_s1_r;
    logic [`SBST_BUMP_W-1:0] pins_s2_r;

    always_ff @(posedge clk_sys_i)
    begin
        rst_sys_r <= rst_n_i;
        ce_sys_r <= ce_i;
    end

    // two flops per crossing; pins cost two tck of lag but never reach capture half-settled
    always_ff @(posedge tck_i)
    begin
        rst_sync_r <= {rst_sync_r[0], rst_sys_r};
        ce_sync_r <= {ce_sync_r[0], ce_sys_r};
        pins_s1_r <= pins_i;
        pins_s2_r <= pins_s1_r;
    end
    assign trst_n = rst_sync_r[1];
    assign tce = ce_sync_r[1];

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            sbst_pkg::ST_RESET:
                state_nxt = link_i.tms ? sbst_pkg::ST_RESET : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_IDLE:
                state_nxt = link_i.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_SEL_DR:
                state_nxt = link_i.tms ? sbst_pkg::ST_SEL_IR : sbst_pkg::ST_CAP_DR;
            sbst_pkg::ST_CAP_DR:
                state_nxt = link_i.tms ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SH_DR;
            sbst_pkg::ST_SH_DR:
                state_nxt = link_i.tms ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SH_DR;
            sbst_pkg::ST_EX1_DR:
                state_nxt = link_i.tms ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_PA_DR;
            sbst_pkg::ST_PA_DR:
                state_nxt = link_i.tms ? sbst_pkg::ST_EX2_DR : sbst_pkg::ST_PA_DR;
            sbst_pkg::ST_EX2_DR:
                state_nxt = link_i.tms ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_SH_DR;
            sbst_pkg::ST_UPD_DR:
                state_nxt = link_i.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_SEL_IR:
                state_nxt = link_i.tms ? sbst_pkg::ST_RESET : sbst_pkg::ST_CAP_IR;
            sbst_pkg::ST_CAP_IR:
                state_nxt = link_i.tms ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SH_IR;
            sbst_pkg::ST_SH_IR:
                state_nxt = link_i.tms ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SH_IR;
            sbst_pkg::ST_EX1_IR:
                state_nxt = link_i.tms ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_PA_IR;
            sbst_pkg::ST_PA_IR:
                state_nxt = link_i.tms ? sbst_pkg::ST_EX2_IR : sbst_pkg::ST_PA_IR;
            sbst_pkg::ST_EX2_IR:
                state_nxt = link_i.tms ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_SH_IR;
            sbst_pkg::ST_UPD_IR:
                state_nxt = link_i.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
            default: state_nxt = sbst_pkg::ST_RESET;
        endcase
    end

    always_ff @(posedge tck_i)
    begin
        if (!trst_n)
            state_r <= sbst_pkg::ST_RESET;
        else if (tce)
            state_r <= state_nxt;
    end

    // instruction shift and update
    always_ff @(posedge tck_i)
    begin
        if (!trst_n)
        begin
            ir_sh_r <= `SBST_IR_CAPTURE;
            ir_r <= `SBST_IR_IDCODE;
        end
        else if (tce)
        begin
            unique case (state_r)
                sbst_pkg::ST_RESET: ir_r <= `SBST_IR_IDCODE;
                sbst_pkg::ST_CAP_IR: ir_sh_r <= `SBST_IR_CAPTURE;
                sbst_pkg::ST_SH_IR: ir_sh_r <= {link_i.tdi, ir_sh_r[`SBST_IR_W-1:1]};
                sbst_pkg::ST_UPD_IR: ir_r <= ir_sh_r;
                default: ir_r <= ir_r;
            endcase
        end
    end

    // codes 011/101/110 are never loaded by a well-behaved controller; they fall to bypass
    assign sel_bsr = (ir_r == `SBST_IR_EXTEST) || (ir_r == `SBST_IR_SAMPLEZ)
                   || (ir_r == `SBST_IR_SAMPLE);

    // data registers
    always_ff @(posedge tck_i)
    begin
        if (!trst_n)
        begin
            byp_r <= 1'b0;
            id_r <= '0;
            bsr_r <= '0;
        end
        else if (tce)
        begin
            if (state_r == sbst_pkg::ST_CAP_DR)
            begin
                byp_r <= 1'b0;
                if (ir_r == `SBST_IR_IDCODE)
                    id_r <= ID_CODE;
                if (sel_bsr)
                    bsr_r <= {upd_r[`SBST_OEN_CELL_IDX], pins_s2_r};
            end
            else if (state_r == sbst_pkg::ST_SH_DR)
            begin
                if (ir_r == `SBST_IR_IDCODE)
                    id_r <= {link_i.tdi, id_r[`SBST_ID_W-1:1]};
                else if (sel_bsr)
                    bsr_r <= {link_i.tdi, bsr_r[`SBST_BSR_W-1:1]};
                else
                    byp_r <= link_i.tdi;
            end
        end
    end

    // update latches; cell 108 presets high in reset and test-logic-reset
    always_ff @(posedge tck_i)
    begin
        if (!trst_n)
            upd_r <= {1'b1, {`SBST_BUMP_W{1'b0}}};
        else if (tce)
        begin
            if (state_r == sbst_pkg::ST_RESET)
                upd_r[`SBST_OEN_CELL_IDX] <= 1'b1;
            else if (state_r == sbst_pkg::ST_UPD_DR && sel_bsr)
                upd_r <= bsr_r;
        end
    end

    always_comb
    begin
        if (state_r == sbst_pkg::ST_SH_IR)
            tdo_nxt = ir_sh_r[0];
        else if (ir_r == `SBST_IR_IDCODE)
            tdo_nxt = id_r[0];
        else if (sel_bsr)
            tdo_nxt = bsr_r[0];
        else
            tdo_nxt = byp_r;
    end

    // serial output changes at the falling test-clock edge, as the link expects
    always_ff @(negedge tck_i)
    begin
        if (!trst_n)
        begin
            tdo_o <= 1'b0;
            tdo_oe_n_o <= 1'b1;
        end
        else if (tce)
        begin
            tdo_o <= tdo_nxt;
            tdo_oe_n_o <= !(state_r == sbst_pkg::ST_SH_IR || state_r == sbst_pkg::ST_SH_DR);
        end
    end

    always_ff @(posedge tck_i)
    begin
        if (!trst_n)
        begin
            extest_o <= 1'b0;
            q_drive_en_o <= 1'b1;
        end
        else if (tce)
        begin
            extest_o <= (ir_r == `SBST_IR_EXTEST);
            if (ir_r == `SBST_IR_SAMPLEZ)
                q_drive_en_o <= 1'b0;
            else if (ir_r == `SBST_IR_EXTEST)
                q_drive_en_o <= upd_r[`SBST_OEN_CELL_IDX];
            else
                q_drive_en_o <= 1'b1;
        end
    end

    assign pins_o = upd_r[`SBST_BUMP_W-1:0];
    assign ir_o = ir_r;
endmodule : sbst_tap

// [verif/sbst_ctl.sv]
`timescale 1ns/1ps
module sbst_ctl (
    input wire logic tck_i,
    input wire logic tdo_i,
    input wire logic tdo_oe_n_i,
    output sbst_pkg::sbst_link_t link_o
);
    initial link_o = '0;
    // change after the rise so the port samples a settled value
    task automatic step(input logic m, input logic d, output logic q);
        link_o <= '{tms: m, tdi: d};
        @(posedge tck_i);
        // a released serial line floats to its pull-up
        q = tdo_oe_n_i ? 1'b1 : tdo_i;
    endtask : step
    task automatic scan(input logic ir, input logic [127:0] din, input int n,
        output logic [127:0] dout);
        logic q;
        step(1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask : scan
endmodule : sbst_ctl

// [verif/sbst_tap_asserts.sv]
`timescale 1ns/1ps
`include "sbst_cfg.svh"
module sbst_tap_asserts (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic tck_i,
    input wire sbst_pkg::sbst_link_t link_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_n_o,
    input wire logic [`SBST_BUMP_W-1:0] pins_o,
    input wire logic extest_o,
    input wire logic q_drive_en_o,
    input wire logic [`SBST_IR_W-1:0] ir_o
);
    ext_flag_a: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        $stable(ir_o) |-> extest_o == (ir_o == 3'h0)) else $error("extest flag");
    q_float_a: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        $stable(ir_o) && ir_o == 3'h2 |-> !q_drive_en_o) else $error("q not floated");
    q_drive_a: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        $stable(ir_o) && ir_o inside {3'h1, 3'h4, 3'h7} |-> q_drive_en_o)
        else $error("q disturbed");
    tms_reset_a: assert property (@(posedge tck_i) disable iff (!rst_n_i || !ce_i)
        link_i.tms [*5] |-> ##[0:2] ir_o == 3'h1) else $error("no tms reset");
    // what stands at a rise must still stand just before the next fall
    logic [1:0] tdo_rise_r;
    always_ff @(posedge tck_i)
        tdo_rise_r <= {tdo_o, tdo_oe_n_o};
    tdo_fall_a: assert property (@(negedge tck_i) disable iff (!rst_n_i)
        {tdo_o, tdo_oe_n_o} == tdo_rise_r) else $error("tdo on rise");
    ir_hold_a: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        !tdo_oe_n_o |=> $stable(ir_o)) else $error("ir moved in shift");
    pins_hold_a: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        !tdo_oe_n_o |=> $stable(pins_o)) else $error("pins moved in shift");
    ir_upd_a: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        $changed(ir_o) |-> tdo_oe_n_o && $past(tdo_oe_n_o)) else $error("ir update early");
    cover property (@(posedge tck_i) ir_o == 3'h0 && !q_drive_en_o);
    cover property (@(posedge tck_i) ir_o == 3'h2);
    cover property (@(posedge tck_i) ir_o == 3'h7 && !tdo_oe_n_o);
endmodule : sbst_tap_asserts
bind sbst_tap sbst_tap_asserts u_chk (.clk_sys_i, .rst_n_i, .ce_i, .tck_i, .link_i, .tdo_o,
    .tdo_oe_n_o, .pins_o, .extest_o, .q_drive_en_o, .ir_o);

// [verif/tb_top.sv]
`timescale 1ns/1ps
`include "sbst_cfg.svh"
module tb_top;
    localparam logic [31:0] ID_EXP = {`SBST_ID_REV, `SBST_ID_PART, `SBST_ID_MAKER, 1'b1};
    logic clk = 1'b0;
    logic tck = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic tdo, oe_n, ext, qen, q, c108;
    logic [2:0] ir;
    logic [107:0] pins = '0;
    logic [107:0] po;
    logic [127:0] din, dout;
    logic [2:0] codes [5] = '{3'h4, 3'h0, 3'h2, 3'h1, 3'h7};
    sbst_pkg::sbst_link_t link;
    int n_mismatch = 0;
    int num_checks = 0;
    int len;
    always #4 clk = ~clk;
    always #7.5 tck = ~tck;
    sbst_tap uut (.clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(ce), .tck_i(tck), .link_i(link),
        .tdo_o(tdo), .tdo_oe_n_o(oe_n), .pins_i(pins), .pins_o(po), .extest_o(ext),
        .q_drive_en_o(qen), .ir_o(ir));
    sbst_ctl ctl (.tck_i(tck), .tdo_i(tdo), .tdo_oe_n_i(oe_n), .link_o(link));
    task check(input logic [127:0] s, input logic [127:0] e);
        num_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask : check
    task idle;
        ctl.step(1'b0, 1'b0, q);
        #1;
    endtask : idle
    task stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    initial
    begin
        #100000;
        n_mismatch++;
        stop_test();
    end
    initial
    begin
        void'($urandom(99));
        // reset must pass the launch flop and the two-stage sync before it lands
        repeat (4) @(posedge tck);
        #1;
        check({ir, oe_n, qen}, 5'b00111);
        @(posedge clk) rst_n <= 1'b1;
        repeat (5) idle;
        ctl.scan(1'b0, '0, 32, dout);
        check(dout[31:0], ID_EXP);
        c108 = 1'b1;
        foreach (codes[k])
        begin
            for (int i = 0; i < 4; i++) din[i*32 +: 32] = $urandom;
            @(posedge clk) pins <= din[107:0];
            ctl.scan(1'b1, {125'h0, codes[k]}, 3, dout);
            check(dout[1:0], 2'b01);
            idle;
            check({ir, ext}, {codes[k], codes[k] == 3'h0});
            check(qen, codes[k] == 3'h2 ? 1'b0 : codes[k] != 3'h0 | c108);
            din[116] = codes[k] != 3'h4;
            len = codes[k] == 3'h7 ? 1 : codes[k] == 3'h1 ? 32 : 109;
            ctl.scan(1'b0, din, len + 8, dout);
            idle;
            check(dout[len +: 8], din[7:0]);
            if (len == 1) check(dout[0], 1'b0);
            if (len == 32) check(dout[31:0], ID_EXP);
            if (len == 109)
            begin
                check(dout[108:0], {c108, pins});
                c108 = din[116];
            end
            if (codes[k] == 3'h0) check({qen, po}, {c108, din[115:8]});
            else if (codes[k] == 3'h4) check(po, din[115:8]);
        end
        // a low enable must hold off even a five-edge mode-select reset
        @(posedge clk) ce <= 1'b0;
        repeat (4) idle;
        repeat (6) ctl.step(1'b1, 1'b0, q);
        idle;
        @(posedge clk) ce <= 1'b1;
        repeat (4) idle;
        check(ir, 3'h7);
        repeat (5) ctl.step(1'b1, 1'b0, q);
        idle;
        check(ir, 3'h1);
        stop_test();
    end
endmodule : tb_top
